/* File: inc/upa_pkg.sv */
// Notes on behaviour
// [RULE_01] pipe 0 address in bits 6..0
// [RULE_02] pipe 1 address in bits 14..8
// [RULE_03] pipe 2 address in bits 22..16
// [RULE_04] pipe 3 address in bits 30..24
// [RULE_05] bus reset request clears all addresses
// [RULE_06] bank code 0/1/2 gives 1/2/3 banks
// [RULE_07] software uses one bank for control pipes
// [RULE_08] sent bus reset clears bank count
// [RULE_09] writing one allocates pipe memory
// [RULE_10] writing zero frees pipe memory
// [RULE_11] bus reset request clears allocate bit
// [RULE_12] address register read-write, resets to zero
// [RULE_13] bits 31,23,15,7 read zero, ignore writes
package upa_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_PIPE_ADDR = 12'h424;
  localparam logic [ADDR_W-1:0] OFS_PIPE_CFG = 12'h500;
  localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 12'h600;
  localparam int TADDR_W = 7;
  localparam int FIELD_STRIDE = 8;
  localparam int NUM_PIPES = 4;
  localparam logic [31:0] ADDR_REG_MASK = 32'h7F7F7F7F;
  localparam logic [31:0] ADDR_REG_RESET = 32'h00000000;
  localparam int CFG_BANK_LSB = 2;
  localparam int CFG_PIPE_MEM_ALLOCATE_BIT = 1;
  localparam int CTRL_RESET_BIT = 0;
  localparam logic [1:0] BANK_ONE = 2'h0;
  localparam logic [1:0] BANK_TWO = 2'h1;
  localparam logic [1:0] BANK_THREE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : upa_pkg

/* File: hdl/upa_host_pipe_addr.sv */
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module upa_host_pipe_addr
  import upa_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  // axi4-lite write response
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  // axi4-lite read data
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // link side
  input wire logic bus_reset_sent_i,
  output logic bus_reset_req_o,
  output logic [NUM_PIPES*TADDR_W-1:0] pipe_target_addr_o,
  output logic [1:0] pipe_bank_count_o,
  output logic [1:0] pipe_num_banks_o,
  output logic pipe_mem_allocate_o
);

  logic [31:0] addr_reg_q;
  logic [1:0] bank_q;
  logic pipe_mem_allocate_q;
  logic rst_req_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // one write in flight: take each half once, hold until response leaves
  assign s_awready_o = !aw_have_q && !bvalid_q;
  assign s_wready_o = !w_have_q && !bvalid_q;
  wire aw_fire = s_awvalid_i && s_awready_o;
  wire w_fire = s_wvalid_i && s_wready_o;
  wire aw_ok = aw_have_q || aw_fire;
  wire w_ok = w_have_q || w_fire;
  wire [ADDR_W-1:0] wr_addr = aw_have_q ? awaddr_q : s_awaddr_i;
  wire [31:0] wr_data = w_have_q ? wdata_q : s_wdata_i;
  wire [3:0] wr_strb = w_have_q ? wstrb_q : s_wstrb_i;
  wire wr_go = aw_ok && w_ok && !bvalid_q;
  wire wr_addr_hit = wr_go && (wr_addr == OFS_PIPE_ADDR);
  wire wr_cfg_hit = wr_go && (wr_addr == OFS_PIPE_CFG);
  wire wr_ctrl_hit = wr_go && (wr_addr == OFS_BUS_CTRL);
  wire wr_mapped = wr_addr_hit || wr_cfg_hit || wr_ctrl_hit;

  logic [31:0] strb_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign strb_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  // reserved bits stay zero whatever is written
  wire [31:0] addr_merge = (addr_reg_q & ~strb_mask) |
    (wr_data & strb_mask); // [RULE_13]
  wire [31:0] addr_reg_d = rst_req_q ? ADDR_REG_RESET :
    wr_addr_hit ? (addr_merge & ADDR_REG_MASK) : addr_reg_q; // [RULE_05]

  wire cfg_lane0 = wr_cfg_hit && wr_strb[0];
  wire [1:0] bank_d = bus_reset_sent_i ? BANK_ONE :
    cfg_lane0 ? wr_data[CFG_BANK_LSB +: 2] : bank_q; // [RULE_08]
  // allocate follows the written bit; request for bus reset frees it
  wire pipe_mem_allocate_d = rst_req_q ? 1'b0 :
    cfg_lane0 ? wr_data[CFG_PIPE_MEM_ALLOCATE_BIT] : pipe_mem_allocate_q; // [RULE_09] [RULE_10] [RULE_11]
  // request holds until the link reports the reset sent
  wire rst_req_d = (wr_ctrl_hit && wr_strb[0]) ? wr_data[CTRL_RESET_BIT] :
    bus_reset_sent_i ? 1'b0 : rst_req_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_reg_q <= ADDR_REG_RESET; // [RULE_12]
      bank_q <= BANK_ONE;
      pipe_mem_allocate_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      addr_reg_q <= addr_reg_d;
      bank_q <= bank_d;
      pipe_mem_allocate_q <= pipe_mem_allocate_d;
      rst_req_q <= rst_req_d;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_q <= s_awaddr_i;
      end
      if (w_fire) begin
        wdata_q <= s_wdata_i;
        wstrb_q <= s_wstrb_i;
      end
      aw_have_q <= wr_go ? 1'b0 : aw_ok;
      w_have_q <= wr_go ? 1'b0 : w_ok;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bresp_q;

  // read path: answer one cycle after address taken
  assign s_arready_o = !rvalid_q;
  wire ar_fire = s_arvalid_i && s_arready_o;
  wire rd_addr_hit = s_araddr_i == OFS_PIPE_ADDR;
  wire rd_cfg_hit = s_araddr_i == OFS_PIPE_CFG;
  wire rd_ctrl_hit = s_araddr_i == OFS_BUS_CTRL;
  wire [31:0] cfg_word = ({30'h0, bank_q} << CFG_BANK_LSB) |
    ({31'h0, pipe_mem_allocate_q} << CFG_PIPE_MEM_ALLOCATE_BIT);
  wire [31:0] ctrl_word = {31'h0, rst_req_q} << CTRL_RESET_BIT;
  wire [31:0] rd_word = rd_addr_hit ? (addr_reg_q & ADDR_REG_MASK) :
    rd_cfg_hit ? cfg_word : rd_ctrl_hit ? ctrl_word : 32'h00000000;
  wire rd_mapped = rd_addr_hit || rd_cfg_hit || rd_ctrl_hit;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o = rdata_q;
  assign s_rresp_o = rresp_q;

  generate
    for (gi = 0; gi < NUM_PIPES; gi++) begin : g_pipe
      assign pipe_target_addr_o[gi*TADDR_W +: TADDR_W] =
        addr_reg_q[gi*FIELD_STRIDE +: TADDR_W]; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
    end
  endgenerate

  // reserved code 3 treated as three banks; control pipes need code 0
  assign pipe_num_banks_o = (bank_q == BANK_ONE) ? 2'h1 :
    (bank_q == BANK_TWO) ? 2'h2 : 2'h3; // [RULE_06] [RULE_07]
  assign pipe_bank_count_o = bank_q;
  assign pipe_mem_allocate_o = pipe_mem_allocate_q;
  assign bus_reset_req_o = rst_req_q;

  reset_clears_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rst_req_q |=> (addr_reg_q == 32'h00000000) && !pipe_mem_allocate_q) // [RULE_05]
    else $error("addresses not cleared on reset request");
  bank_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_reset_sent_i |=> bank_q == 2'h0) // [RULE_08]
    else $error("bank count not cleared");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (addr_reg_q & 32'h80808080) == 32'h00000000) // [RULE_13]
    else $error("reserved address bits set");
  addr_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && (wr_strb == 4'hF) |=>
    addr_reg_q == ($past(wr_data) & 32'h7F7F7F7F)) // [RULE_01]
    else $error("address write lost");
  pipe3_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && wr_strb[3] |=>
    pipe_target_addr_o[27:21] == $past(wr_data[30:24])) // [RULE_04]
    else $error("pipe 3 address mismatch");
  pipe_mem_allocate_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cfg_lane0 && !rst_req_q |=> pipe_mem_allocate_q == $past(wr_data[1])) // [RULE_09]
    else $error("allocate bit not written");
  pipe_mem_allocate_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !cfg_lane0 && !rst_req_q |=> $stable(pipe_mem_allocate_q)) // [RULE_10]
    else $error("allocate bit changed");
  banks_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bank_q == 2'h1 |-> pipe_num_banks_o == 2'h2) // [RULE_06]
    else $error("bank mapping wrong");
  read_answer_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire |=> s_rvalid_o) // [RULE_12]
    else $error("read not answered");
  resp_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_bvalid_o && s_bready_i && !wr_go |=> !s_bvalid_o)
    else $error("write response stuck");

  // handshake: each half taken once, answers stand until taken
  aw_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    aw_have_q || s_bvalid_o |-> !s_awready_o)
    else $error("write address taken twice");
  w_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    w_have_q || s_bvalid_o |-> !s_wready_o)
    else $error("write data taken twice");
  ar_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rvalid_o |-> !s_arready_o)
    else $error("read address taken while busy");
  aw_capture_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    aw_fire && !wr_go |=> aw_have_q)
    else $error("write address half lost");
  w_capture_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    w_fire && !wr_go |=> w_have_q)
    else $error("write data half lost");
  wr_answer_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_go |=> s_bvalid_o)
    else $error("write not answered");
  b_stand_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_bvalid_o && !s_bready_i |=>
    s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped");
  r_stand_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rvalid_o && !s_rready_i |=>
    s_rvalid_o && $stable(s_rdata_o) && $stable(s_rresp_o))
    else $error("read data dropped");
  r_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rvalid_o && s_rready_i |=> !s_rvalid_o)
    else $error("read response stuck");

  // decode: unmapped offsets answer with an error and no data
  wr_unmapped_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_go && !wr_mapped |=> s_bresp_o == RESP_SLVERR)
    else $error("unmapped write not refused");
  wr_mapped_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_go && wr_mapped |=> s_bresp_o == RESP_OKAY)
    else $error("mapped write refused");
  rd_unmapped_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire && !rd_mapped |=>
    s_rresp_o == RESP_SLVERR && s_rdata_o == 32'h00000000)
    else $error("unmapped read not refused");
  rd_addr_data_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire && rd_addr_hit |=>
    s_rdata_o == ($past(addr_reg_q) & ADDR_REG_MASK)) // [RULE_12]
    else $error("address register read wrong");
  rd_reserved_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire && rd_addr_hit |=>
    (s_rdata_o & ~ADDR_REG_MASK) == 32'h00000000) // [RULE_13]
    else $error("reserved bits read as one");
  rd_cfg_data_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire && rd_cfg_hit |=>
    s_rdata_o[CFG_BANK_LSB +: 2] == $past(bank_q) &&
    s_rdata_o[CFG_PIPE_MEM_ALLOCATE_BIT] == $past(pipe_mem_allocate_q)) // [RULE_06] [RULE_09]
    else $error("config read wrong");
  rd_ctrl_data_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ar_fire && rd_ctrl_hit |=>
    s_rdata_o[CTRL_RESET_BIT] == $past(rst_req_q))
    else $error("control read wrong");

  // address fields: only a write or a reset request moves them
  addr_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !wr_addr_hit && !rst_req_q |=>
    $stable(addr_reg_q)) // [RULE_12]
    else $error("address register changed");
  lane_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && !wr_strb[0] |=>
    addr_reg_q[7:0] == $past(addr_reg_q[7:0])) // [RULE_01]
    else $error("unstrobed lane written");
  pipe0_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && wr_strb[0] |=>
    pipe_target_addr_o[6:0] == $past(wr_data[6:0])) // [RULE_01]
    else $error("pipe 0 address mismatch");
  pipe1_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && wr_strb[1] |=>
    pipe_target_addr_o[13:7] == $past(wr_data[14:8])) // [RULE_02]
    else $error("pipe 1 address mismatch");
  pipe2_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_addr_hit && !rst_req_q && wr_strb[2] |=>
    pipe_target_addr_o[20:14] == $past(wr_data[22:16])) // [RULE_03]
    else $error("pipe 2 address mismatch");
  taddr_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rst_req_q |=>
    pipe_target_addr_o == '0) // [RULE_05]
    else $error("pipe addresses kept on reset request");

  // configuration and reset request
  bank_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cfg_lane0 && !bus_reset_sent_i |=>
    bank_q == $past(wr_data[CFG_BANK_LSB +: 2])) // [RULE_06]
    else $error("bank count not written");
  bank_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !cfg_lane0 && !bus_reset_sent_i |=>
    $stable(bank_q)) // [RULE_08]
    else $error("bank count changed");
  banks_one_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bank_q == BANK_ONE |-> pipe_num_banks_o == 2'h1) // [RULE_06]
    else $error("single bank mapping wrong");
  banks_three_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bank_q == BANK_THREE |-> pipe_num_banks_o == 2'h3) // [RULE_06]
    else $error("triple bank mapping wrong");
  pipe_mem_allocate_free_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cfg_lane0 && !rst_req_q && !wr_data[CFG_PIPE_MEM_ALLOCATE_BIT] |=>
    !pipe_mem_allocate_o) // [RULE_10]
    else $error("pipe memory not freed");
  pipe_mem_allocate_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rst_req_q |=> !pipe_mem_allocate_o) // [RULE_11]
    else $error("allocate kept on reset request");
  ctrl_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_ctrl_hit && wr_strb[0] |=>
    bus_reset_req_o == $past(wr_data[CTRL_RESET_BIT]))
    else $error("reset request not written");
  req_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rst_req_q && !bus_reset_sent_i && !(wr_ctrl_hit && wr_strb[0]) |=>
    bus_reset_req_o)
    else $error("reset request dropped early");
  req_drop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_reset_sent_i && !(wr_ctrl_hit && wr_strb[0]) |=>
    !bus_reset_req_o)
    else $error("reset request kept after sent");

  wr_seen_c: cover property (@(posedge clk_i) wr_addr_hit);
  rd_seen_c: cover property (@(posedge clk_i) ar_fire && rd_addr_hit);
  pipe_mem_allocate_c: cover property (@(posedge clk_i) pipe_mem_allocate_q ##1 rst_req_q);
  bank_c: cover property (@(posedge clk_i) bank_q == 2'h2);
  sent_c: cover property (@(posedge clk_i) rst_req_q && bus_reset_sent_i);

endmodule : upa_host_pipe_addr

/* File: tb/upa_link_model.sv */
`timescale 1ns/1ps
module upa_link_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request from the controller, answer delay
  input wire logic bus_reset_req_i,
  input wire logic [3:0] delay_i,
  output logic bus_reset_sent_o
);
  logic [3:0] cnt_q;
  logic sent_q;
  logic due;
  // one pulse per request, delay_i+1 cycles after the request is first seen
  assign due = bus_reset_req_i && !sent_q && cnt_q == delay_i;
  assign bus_reset_sent_o = sent_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 4'h0;
      sent_q <= 1'h0;
    end else begin
      sent_q <= due;
      cnt_q <= (bus_reset_req_i && !sent_q && !due) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : upa_link_model

/* File: tb/test_usb_host_pipe_addr_config.sv */
`timescale 1ns/1ps
module test_usb_host_pipe_addr_config;
  import upa_pkg::*;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = '0, rdata, rdat, lf = 32'hC421, m_addr;
  logic [1:0] bresp, rresp, resp, bank, nbanks;
  logic awready, wready, bvalid, arready, rvalid, sent, req, pipe_mem_allocate;
  logic [NUM_PIPES*TADDR_W-1:0] taddr;
  logic [3:0] delay = 4'h0, strb = 4'hF;
  int n_mismatch = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  upa_host_pipe_addr i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(strb), .s_wvalid_i(wvalid),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
    .s_rvalid_o(rvalid), .s_rready_i(rready), .bus_reset_sent_i(sent),
    .bus_reset_req_o(req), .pipe_target_addr_o(taddr),
    .pipe_bank_count_o(bank), .pipe_num_banks_o(nbanks),
    .pipe_mem_allocate_o(pipe_mem_allocate));
  upa_link_model i_link (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .bus_reset_req_i(req), .delay_i(delay), .bus_reset_sent_o(sent));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'h0} ^ (v[31] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // handshakes sampled mid-cycle: inputs only move at the rising edge
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      resp = bresp;
      @(posedge clk_i);
      if (aw_t) awvalid <= 1'h0;
      if (w_t) wvalid <= 1'h0;
    end while (b_t !== 1'h1);
    bready <= 1'h0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a);
    logic ar_t, r_t;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk_i);
      ar_t = arvalid && arready;
      r_t = rvalid;
      rdat = rdata;
      resp = rresp;
      @(posedge clk_i);
      if (ar_t) arvalid <= 1'h0;
    end while (r_t !== 1'h1);
    rready <= 1'h0;
  endtask : rd
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #100us;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'h1;
    rd(OFS_PIPE_ADDR);
    chk("addr_reset", ADDR_REG_RESET, rdat);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      m_addr = (i == 0 ? 32'hFFFFFFFF : lf) & ADDR_REG_MASK;
      wr(OFS_PIPE_ADDR, i == 0 ? 32'hFFFFFFFF : lf);
      rd(OFS_PIPE_ADDR);
      chk("addr_reg", m_addr, rdat);
      for (int p = 0; p < NUM_PIPES; p++)
        chk("pipe_addr", m_addr[8*p +: 7], taddr[7*p +: 7]);
    end
    strb <= 4'h2;
    wr(OFS_PIPE_ADDR, 32'hFFFFFFFF);
    strb <= 4'hF;
    m_addr = m_addr | 32'h00007F00;
    rd(OFS_PIPE_ADDR);
    chk("addr_strb", m_addr, rdat);
    // code 0 first: pipe 0 serves the control endpoint
    for (int c = 0; c < 4; c++) begin
      wr(OFS_PIPE_CFG, (c << CFG_BANK_LSB) | 32'h2);
      chk("bank_count", c, bank);
      chk("num_banks", c == 0 ? 1 : c == 1 ? 2 : 3, nbanks);
      chk("pipe_mem_allocate_set", 32'h1, pipe_mem_allocate);
    end
    wr(OFS_PIPE_CFG, 32'h8);
    chk("pipe_mem_allocate_free", 32'h0, pipe_mem_allocate);
    rd(12'h7F0);
    chk("unmapped_resp", RESP_SLVERR, resp);
    chk("unmapped_data", 32'h0, rdat);
    for (int k = 0; k < 2; k++) begin
      delay <= k ? 4'h6 : 4'h0;
      wr(OFS_PIPE_ADDR, 32'h11223344);
      wr(OFS_PIPE_CFG, 32'h6);
      wr(OFS_BUS_CTRL, 32'h1);
      @(posedge clk_i);
      chk("addr_on_req", 32'h0, taddr);
      chk("pipe_mem_allocate_on_req", 32'h0, pipe_mem_allocate);
      for (int j = 0; j < 20 && req !== 1'h0; j++) @(negedge clk_i);
      chk("req_cleared", 32'h0, req);
      @(posedge clk_i);
      chk("bank_on_sent", 32'h0, bank);
      rd(OFS_PIPE_ADDR);
      chk("addr_after", 32'h0, rdat);
    end
    print_verdict;
  end
endmodule : test_usb_host_pipe_addr_config
